// *** core/spdif_tx_regs.svh ***
// Register offsets, field positions, reset values and frame counts of the S/PDIF transmitter
`ifndef SPDIF_TX_REGS_SVH
`define SPDIF_TX_REGS_SVH

`define TX_CTRL_ADDR 7'h1E
`define TX_PWR_ADDR 7'h33

`define CTRL_SRC_LSB 0
`define CTRL_CSOVR_POS 2
`define CTRL_THRU_POS 3
`define CTRL_VOVR_POS 4
`define CTRL_V0_POS 5
`define CTRL_V1_POS 6
`define CTRL_RESET 7'h00
`define PWR_TXPD_POS 4
`define PWR_TXPD_RESET 1'b1

`define SRC_RX 2'h0
`define SRC_ADC 2'h1
`define SRC_SEC 2'h2
`define SRC_PRI 2'h3

`define WORD_V_POS 24
`define WORD_U_POS 25
`define WORD_C_POS 26
`define WORD_P_POS 27

`define FRAMES_PER_BLOCK 8'd192
`define FRAME_LAST 8'd191
`define CS_USED_FRAMES 8'd40
`define PRE_LAST_HALF 6'd7
`define DATA_LAST_HALF 6'd55

// Toggle masks of the preambles, half-cell 0 in bit 0
`define PRE_BLOCK_TOGGLES 8'h39
`define PRE_SUB0_TOGGLES 8'hC9
`define PRE_SUB1_TOGGLES 8'h69

`endif

// *** core/spdif_tx_pkg.sv ***
// Types shared by the S/PDIF transmitter modules
package spdif_tx_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_pre,
    st_data
  } tx_state_e;

  typedef struct packed {
    tx_state_e st;
    logic sub;
    logic [7:0] frame;
    logic [5:0] half;
    logic [27:0] word;
    logic [23:0] cap_r;
    logic [1:0] cap_v;
    logic [1:0] cap_u;
    logic [1:0] cap_c;
    logic [6:0] ctrl;
    logic pwrdn;
    logic [8:0] rdata;
    logic pin;
    logic strobe;
    logic blk;
  } tx_state_s;

  typedef struct packed {
    logic level;
  } enc_state_s;

endpackage

// *** core/bmc_encoder.sv ***
// Bi-phase-mark line level generator driven by per-half-cell toggle requests
`timescale 1ns/1ps
module bmc_encoder (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic half_cell_tick,
  input wire logic toggle,
  input wire logic hold_idle,
  output logic level
);
  import spdif_tx_pkg::*;

  enc_state_s s_q;
  enc_state_s s_d;

  always_comb begin
    s_d = s_q;
    if (clk_en) begin
      if (hold_idle) begin
        s_d.level = 1'b0; // see RL19
      end else if (half_cell_tick && toggle) begin
        s_d.level = ~s_q.level; // see RL1
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_level_toggles: assert property (clk_en && !hold_idle && half_cell_tick && toggle |=> level != $past(level)) // see RL1
    else $error("line level did not toggle");
  a_level_idle: assert property (clk_en && hold_idle |=> !level) // see RL19
    else $error("line not idle low while held");

endmodule

// *** core/spdif_frame_transmitter.sv ***
// S/PDIF frame builder with source select, status overrides, pass-through and power-down
`timescale 1ns/1ps
`include "spdif_tx_regs.svh"

// Summary of operation
// RL1: Bi-phase-mark stream, frames of two sub-frames
// RL2: Preamble marks block start or sub-frame start
// RL3: Four auxiliary bits follow, LSB first
// RL4: Twenty audio bits LSB first, 24-bit sample
// RL5: Validity high means sample invalid
// RL6: One user and channel bit per sub-frame
// RL7: Last bit gives even parity after preamble
// RL8: 192-frame blocks, first 40 carry status
// RL9: Two-bit select picks receiver, ADC, secondary, primary
// RL10: Receiver source: override picks programmed channel status
// RL11: Pass-through puts input mux on output pin
// RL12: No override: validity zero, or received for receiver
// RL13: Override: validity from per-sub-frame control bits
// RL14: Power-down bit disables, resets to disabled
// RL15: Transmitter builds preamble and trailer bits itself
// RL16: No shared clock assumed; paced by tick
// RL17: User bit zero unless receiver forwards it
// RL18: Status shared except per-sub-frame channel number
// RL19: Idle low while down, restart at block
module spdif_frame_transmitter (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic half_cell_tick,
  input wire logic reg_wr_en,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic [23:0] rx_audio_l,
  input wire logic [23:0] rx_audio_r,
  input wire logic [1:0] rx_validity,
  input wire logic [1:0] rx_user,
  input wire logic [1:0] rx_chan,
  input wire logic [23:0] adc_audio_l,
  input wire logic [23:0] adc_audio_r,
  input wire logic [23:0] primary_audio_if_l,
  input wire logic [23:0] primary_audio_if_r,
  input wire logic [23:0] secondary_audio_if_l,
  input wire logic [23:0] secondary_audio_if_r,
  input wire logic [39:0] prog_chan_status,
  input wire logic [3:0] chan_num_sub0,
  input wire logic [3:0] chan_num_sub1,
  input wire logic spdif_in_mux,
  output logic serial_out_pin,
  output logic sample_strobe,
  output logic block_start,
  output logic [8:0] reg_rd_data
);
  import spdif_tx_pkg::*;

  tx_state_s s_q;
  tx_state_s s_d;
  logic enc_level;
  logic enc_toggle;
  logic [1:0] src;
  logic [23:0] fresh_l;
  logic [23:0] fresh_r;
  logic [1:0] fresh_v;
  logic [1:0] fresh_u;
  logic load;
  logic [7:0] pre_mask;

  function automatic logic is_rx_src(input logic [1:0] sel);
    is_rx_src = (sel == `SRC_RX);
  endfunction

  function automatic logic cs_bit(input logic [39:0] cs_in, input logic [3:0] chnum, input logic [7:0] fr);
    logic [39:0] cs;
    cs = cs_in;
    cs[23:20] = chnum; // see RL18
    cs_bit = (fr < `CS_USED_FRAMES) ? cs[fr[5:0]] : 1'b0; // see RL8
  endfunction

  // Parity covers aux, audio, V, U and C so the 28 bits XOR to zero
  function automatic logic [27:0] build_word(input logic [23:0] a, input logic v, input logic u, input logic c);
    build_word = {^{a, v, u, c}, c, u, v, a}; // see RL5, RL7
  endfunction

  assign src = s_q.ctrl[`CTRL_SRC_LSB +: 2];

  always_comb begin
    case (src) // see RL9
      `SRC_RX: begin
        fresh_l = rx_audio_l;
        fresh_r = rx_audio_r;
      end
      `SRC_ADC: begin
        fresh_l = adc_audio_l;
        fresh_r = adc_audio_r;
      end
      `SRC_SEC: begin
        fresh_l = secondary_audio_if_l;
        fresh_r = secondary_audio_if_r;
      end
      default: begin
        fresh_l = primary_audio_if_l;
        fresh_r = primary_audio_if_r;
      end
    endcase
    if (s_q.ctrl[`CTRL_VOVR_POS]) begin
      fresh_v = {s_q.ctrl[`CTRL_V1_POS], s_q.ctrl[`CTRL_V0_POS]}; // see RL13
    end else begin
      fresh_v = is_rx_src(src) ? rx_validity : 2'b00; // see RL12
    end
    fresh_u = is_rx_src(src) ? rx_user : 2'b00; // see RL17
  end

  // Channel bit follows the receiver only when not overridden
  function automatic logic pick_c(input logic [1:0] sel, input logic ovr, input logic rx_c, input logic pc);
    pick_c = (is_rx_src(sel) && !ovr) ? rx_c : pc; // see RL10
  endfunction

  always_comb begin
    s_d = s_q;
    load = 1'b0;
    // Pulses stand while frozen, like every other state bit
    if (clk_en) begin
      s_d.strobe = 1'b0;
      s_d.blk = 1'b0;
      if (reg_wr_en && reg_addr == `TX_CTRL_ADDR) begin
        s_d.ctrl = reg_wdata[6:0];
      end
      if (reg_wr_en && reg_addr == `TX_PWR_ADDR) begin
        s_d.pwrdn = reg_wdata[`PWR_TXPD_POS]; // see RL14
      end
      case (reg_addr)
        `TX_CTRL_ADDR: s_d.rdata = {2'b00, s_q.ctrl};
        `TX_PWR_ADDR: s_d.rdata = {4'h0, s_q.pwrdn, 4'h0};
        default: s_d.rdata = 9'h000;
      endcase
      case (s_q.st)
        st_idle: begin
          if (!s_q.pwrdn) begin
            s_d.st = st_pre;
            s_d.frame = 8'h00; // see RL19
            s_d.sub = 1'b0;
            s_d.half = 6'h00;
            load = 1'b1;
          end
        end
        st_pre: begin
          if (half_cell_tick) begin // see RL16
            if (s_q.half == `PRE_LAST_HALF) begin
              s_d.st = st_data;
              s_d.half = 6'h00;
            end else begin
              s_d.half = s_q.half + 6'h01;
            end
          end
        end
        st_data: begin
          if (half_cell_tick) begin
            if (s_q.half == `DATA_LAST_HALF) begin
              s_d.st = st_pre;
              s_d.half = 6'h00;
              if (!s_q.sub) begin
                s_d.sub = 1'b1; // see RL1
                s_d.word = build_word(s_q.cap_r, s_q.cap_v[1], s_q.cap_u[1],
                  pick_c(src, s_q.ctrl[`CTRL_CSOVR_POS], s_q.cap_c[1],
                  cs_bit(prog_chan_status, chan_num_sub1, s_q.frame))); // see RL15
              end else begin
                s_d.sub = 1'b0;
                s_d.frame = (s_q.frame == `FRAME_LAST) ? 8'h00 : s_q.frame + 8'h01; // see RL8
                load = 1'b1;
              end
            end else begin
              s_d.half = s_q.half + 6'h01;
            end
          end
        end
        default: s_d.st = st_idle;
      endcase
      // Sub-frame 0 is built from the sample taken at the frame boundary
      if (load) begin
        s_d.cap_r = fresh_r;
        s_d.cap_v = fresh_v;
        s_d.cap_u = fresh_u;
        s_d.cap_c = rx_chan;
        s_d.strobe = 1'b1;
        s_d.blk = (s_d.frame == 8'h00);
        s_d.word = build_word(fresh_l, fresh_v[0], fresh_u[0],
          pick_c(src, s_q.ctrl[`CTRL_CSOVR_POS], rx_chan[0],
          cs_bit(prog_chan_status, chan_num_sub0, s_d.frame))); // see RL6
      end
      if (s_q.pwrdn) begin
        s_d.st = st_idle; // see RL19
        s_d.half = 6'h00;
      end
      s_d.pin = s_q.ctrl[`CTRL_THRU_POS] ? spdif_in_mux : enc_level; // see RL11
    end
  end

  always_comb begin
    pre_mask = `PRE_SUB0_TOGGLES;
    if (s_q.sub) begin
      pre_mask = `PRE_SUB1_TOGGLES;
    end else if (s_q.frame == 8'h00) begin
      pre_mask = `PRE_BLOCK_TOGGLES; // see RL2
    end
    case (s_q.st)
      st_pre: enc_toggle = pre_mask[s_q.half[2:0]];
      // Every cell opens with a transition; a one adds a mid-cell transition
      st_data: enc_toggle = s_q.half[0] ? s_q.word[s_q.half[5:1]] : 1'b1; // see RL3, RL4
      default: enc_toggle = 1'b0;
    endcase
  end

  bmc_encoder u_enc (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .half_cell_tick(half_cell_tick),
    .toggle(enc_toggle),
    .hold_idle(s_q.st == st_idle),
    .level(enc_level)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.st <= st_idle;
      s_q.ctrl <= `CTRL_RESET;
      s_q.pwrdn <= `PWR_TXPD_RESET; // see RL14
    end else begin
      s_q <= s_d;
    end
  end

  assign serial_out_pin = s_q.pin;
  assign sample_strobe = s_q.strobe;
  assign block_start = s_q.blk;
  assign reg_rd_data = s_q.rdata;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_pre_entry;
    s_q.st != st_pre ##1 s_q.st == st_pre;
  endsequence
  sequence s_data_entry;
    s_q.st != st_data ##1 s_q.st == st_data;
  endsequence
  sequence s_last_frame;
    clk_en && load && s_q.frame == `FRAME_LAST;
  endsequence

  property p_data_after_pre;
    s_data_entry |-> $past(s_q.st) == st_pre && s_q.half == 6'h00;
  endproperty
  property p_pre_starts;
    s_pre_entry |-> s_q.half == 6'h00 && (s_q.sub || sample_strobe);
  endproperty
  property p_thru;
    clk_en && s_q.ctrl[`CTRL_THRU_POS] |=> serial_out_pin == $past(spdif_in_mux);
  endproperty
  property p_tx_pin;
    clk_en && !s_q.ctrl[`CTRL_THRU_POS] |=> serial_out_pin == $past(enc_level);
  endproperty

  a_pre_to_data: assert property (p_data_after_pre) // see RL2
    else $error("data cells did not follow a full preamble");
  a_pre_entry: assert property (p_pre_starts) // see RL1
    else $error("preamble entered without sub-frame setup");
  a_pin_thru: assert property (p_thru) // see RL11
    else $error("pin not following input mux");
  a_pin_tx: assert property (p_tx_pin) // see RL11
    else $error("pin not following encoder");
  a_parity_even: assert property (s_q.st == st_data |-> ^s_q.word == 1'b0) // see RL7
    else $error("sub-frame parity not even");
  a_user_zero: assert property (clk_en && load && !is_rx_src(src) |=> !s_q.word[`WORD_U_POS]) // see RL17
    else $error("user bit set for non-receiver source");
  a_valid_src: assert property (clk_en && load && !s_q.ctrl[`CTRL_VOVR_POS] && !is_rx_src(src) // see RL12
    |=> !s_q.word[`WORD_V_POS])
    else $error("validity set without override");
  a_valid_ovr: assert property (clk_en && load && s_q.ctrl[`CTRL_VOVR_POS] // see RL13
    |=> s_q.word[`WORD_V_POS] == $past(s_q.ctrl[`CTRL_V0_POS]))
    else $error("sub-frame 0 validity not from control bit");
  a_frame_range: assert property (s_q.frame < `FRAMES_PER_BLOCK) // see RL8
    else $error("frame index beyond block");
  // A frozen cycle leaves the line where it was
  a_down_idle: assert property (clk_en && s_q.pwrdn |=> // see RL19
    s_q.st == st_idle ##1 (!enc_level || !$past(clk_en)))
    else $error("transmitter active while powered down");
  a_block_frame: assert property (block_start |-> s_q.frame == 8'h00 && !s_q.sub) // see RL2
    else $error("block start away from frame 0");
  a_valid_rx: assert property (clk_en && load && !s_q.ctrl[`CTRL_VOVR_POS] && is_rx_src(src) |=> // see RL12
    s_q.word[`WORD_V_POS] == $past(rx_validity[0]))
    else $error("receiver validity not forwarded");
  a_user_rx: assert property (clk_en && load && is_rx_src(src) |=> // see RL17
    s_q.word[`WORD_U_POS] == $past(rx_user[0]))
    else $error("receiver user bit not forwarded");
  a_chan_rx: assert property (clk_en && load && is_rx_src(src) && !s_q.ctrl[`CTRL_CSOVR_POS] |=> // see RL10
    s_q.word[`WORD_C_POS] == $past(rx_chan[0]))
    else $error("receiver channel bit not forwarded");
  a_audio_adc: assert property (clk_en && load && src == `SRC_ADC |=> s_q.word[23:0] == $past(adc_audio_l)) // see RL9
    else $error("left sample not from converter");
  a_blk_strobe: assert property (block_start |-> sample_strobe) // see RL2
    else $error("block start without sample capture");
  a_block_wrap: assert property (s_last_frame |=> block_start && s_q.frame == 8'h00) // see RL8
    else $error("block did not wrap after last frame");

endmodule

// *** sim/spdif_rx_model.sv ***
// Line receiver model that decodes bi-phase-mark sub-frames into a queue
`timescale 1ns/1ps
module spdif_rx_model (
  input wire logic clock,
  input wire logic resync,
  input wire logic half_cell_tick,
  input wire logic line
);
  logic [2:0] tick_q = 3'h0;
  logic last_q;
  logic hunt_q;
  logic [7:0] tog_q;
  logic [5:0] cnt_q;
  logic [27:0] word_q;
  logic [1:0] kind_q;
  logic [29:0] rx_q[$];
  // Samples three edges after each tick, once the registered line has settled
  always @(posedge clock) begin
    tick_q <= {tick_q[1:0], half_cell_tick};
    if (resync) begin
      {last_q, tog_q, cnt_q} = 15'h0;
      hunt_q = 1'b1;
      rx_q.delete();
    end else if (tick_q[2]) begin
      tog_q = {line ^ last_q, tog_q[7:1]};
      last_q = line;
      if (hunt_q) begin
        // Two quiet halves in a row never occur in data, so only a true preamble matches
        hunt_q = !(tog_q inside {8'h39, 8'hC9, 8'h69});
        kind_q = tog_q == 8'h39 ? 2'h0 : (tog_q == 8'hC9 ? 2'h1 : 2'h2);
        cnt_q = 6'h0;
      end else begin
        if (cnt_q[0]) word_q[cnt_q[5:1]] = tog_q[7];
        if (cnt_q == 6'd55) begin
          rx_q.push_back({kind_q, word_q});
          hunt_q = 1'b1;
        end
        cnt_q = cnt_q + 6'h1;
      end
    end
  end
endmodule

// *** sim/spdif_frame_transmitter_bench.sv ***
// Self-checking bench of the S/PDIF frame transmitter with a line receiver model
`timescale 1ns/1ps
module spdif_frame_transmitter_bench;
  logic clock = 0, sys_rst = 1, tick = 0, wr = 0, mux = 0, rsy = 1, en = 1, pin, stb, bst;
  logic [6:0] addr = 0, ctl = 0;
  logic [8:0] wdata = 0, rd;
  logic [23:0] au [8];
  logic [1:0] rv = 0, ru = 0, rc = 0;
  logic [39:0] pcs = 0;
  logic [3:0] cn0 = 0, cn1 = 0;
  int miscompares = 0, total_checks = 0;
  int strobes = 0, blocks = 0;

  always #4 clock = ~clock;
  // Half-cell pacing every second cycle keeps a full block short
  always @(negedge clock) tick <= ~tick;

  spdif_frame_transmitter i_dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(en), .half_cell_tick(tick),
    .reg_wr_en(wr), .reg_addr(addr), .reg_wdata(wdata),
    .rx_audio_l(au[0]), .rx_audio_r(au[1]), .rx_validity(rv), .rx_user(ru), .rx_chan(rc),
    .adc_audio_l(au[2]), .adc_audio_r(au[3]), .primary_audio_if_l(au[6]), .primary_audio_if_r(au[7]),
    .secondary_audio_if_l(au[4]), .secondary_audio_if_r(au[5]), .prog_chan_status(pcs),
    .chan_num_sub0(cn0), .chan_num_sub1(cn1), .spdif_in_mux(mux), .serial_out_pin(pin),
    .sample_strobe(stb), .block_start(bst), .reg_rd_data(rd)
  );

  spdif_rx_model i_rx (.clock(clock), .resync(rsy), .half_cell_tick(tick), .line(pin));

  // Counted mid-cycle, where each registered pulse has settled
  always @(negedge clock) begin
    if (!sys_rst) begin
      strobes += int'(stb);
      blocks += int'(bst);
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [29:0] e, logic [29:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(logic [6:0] a, logic [8:0] d);
    wr = 1;
    addr = a;
    wdata = d;
    @(negedge clock) wr = 0;
    // Quiet cycle so back-to-back writes never raise the strobe in the step that lowers it
    @(negedge clock);
  endtask

  task automatic rreg(logic [6:0] a, logic [8:0] e);
    addr = a;
    repeat (2) @(negedge clock);
    chk("reg_rd_data", 30'(e), 30'(rd));
  endtask

  function automatic logic [27:0] exp_word(int fr, int s);
    logic [27:0] w;
    logic [3:0] cn;
    int src;
    src = int'(ctl[1:0]);
    cn = s ? cn1 : cn0;
    w = 28'(au[src * 2 + s]);
    w[24] = ctl[4] ? ctl[5 + s] : (src == 0 && rv[s]);
    w[25] = src == 0 && ru[s];
    if (src == 0 && !ctl[2]) w[26] = rc[s];
    else if (fr < 40) w[26] = (fr >= 20 && fr < 24) ? cn[fr - 20] : pcs[fr];
    w[27] = ^w[26:0];
    return w;
  endfunction

  task automatic run(logic [6:0] c, int n);
    logic [1:0] k;
    int s0, b0;
    ctl = c;
    s0 = strobes;
    b0 = blocks;
    foreach (au[i]) au[i] = 24'($urandom);
    {rv, ru, rc} = 6'($urandom);
    pcs = 40'({$urandom, $urandom});
    {cn0, cn1} = 8'($urandom);
    wreg(7'h1E, {2'h0, c});
    @(negedge clock) rsy = 0;
    wreg(7'h33, 9'h000);
    repeat (n * 300) begin
      @(negedge clock);
      if (i_rx.rx_q.size() >= 2 * n) break;
    end
    // Powers down mid sub-frame on purpose
    wreg(7'h33, 9'h010);
    repeat (4) @(negedge clock);
    // Frames 0..n were loaded before the power-down landed
    chk("sample_strobe count", 30'(n + 1), 30'(strobes - s0));
    chk("block_start count", 30'(n / 192 + 1), 30'(blocks - b0));
    for (int i = 0; i < 2 * n; i++) begin
      k = i % 2 ? 2'h2 : (i % 384 == 0 ? 2'h0 : 2'h1);
      chk("subframe", {k, exp_word(i / 2 % 192, i % 2)}, i_rx.rx_q[i]);
    end
    repeat (8) @(negedge clock) chk("idle pin", 30'h0, 30'(pin));
    rsy = 1;
  endtask

  initial begin
    foreach (au[i]) au[i] = 24'h0;
    void'($urandom(45438));
    repeat (16) @(negedge clock);
    sys_rst = 0;
    rreg(7'h1E, 9'h000);
    rreg(7'h33, 9'h010);
    // Enable low: the write is ignored and the read data holds
    en = 0;
    wreg(7'h1E, 9'h1FF);
    rreg(7'h1E, 9'h010);
    en = 1;
    rreg(7'h1E, 9'h000);
    repeat (40) @(negedge clock) chk("pin after reset", 30'h0, 30'(pin));
    wreg(7'h1E, 9'h1FF);
    wreg(7'h10, 9'h1FF);
    wreg(7'h33, 9'h1EF);
    rreg(7'h1E, 9'h07F);
    rreg(7'h33, 9'h000);
    rreg(7'h10, 9'h000);
    for (int i = 0; i < 32; i++) begin
      mux = 1'($urandom);
      @(negedge clock) chk("pass-through", 30'(mux), 30'(pin));
    end
    wreg(7'h33, 9'h010);
    for (int i = 0; i < 8; i++) run({3'($urandom), 1'b0, i[2], i[1:0]}, 3);
    run(7'h04, 193);
    end_sim;
  end

  // Longest run is about fifty thousand cycles
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    end_sim;
  end
endmodule
